/* rtl/nvl_pkg.sv */
// package for the persistent latch bank: sizes, dominance codes, carriers
// assumes a single clock domain; no software-reachable registers
package nvl_pkg;
  localparam int NVL_COUNT = 16;
  localparam logic NVL_DOM_RESET = 1'h0;
  localparam logic NVL_DOM_SET = 1'h1;
  localparam logic [15:0] NVL_CLEAR_ALL = 16'h0000;
  localparam logic [1:0] NVL_SYNC_RESET = 2'h0;

  // persistent store handshake: restore word in at boot, save word out on change
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } nvl_word_type;

  typedef enum logic [2:0] {
    NVL_ST_RESET = 3'b001,
    NVL_ST_RESTORE = 3'b010,
    NVL_ST_RUN = 3'b100
  } nvl_state_type;
endpackage : nvl_pkg

/* rtl/nvl_latch_cell.sv */
// one set/reset latch cell with selectable dominance
// assumes set and reset are already synchronous to clk
`timescale 1ns/1ps
module nvl_latch_cell
  import nvl_pkg::*;
(
  // state
  input wire logic current,
  // controls
  input wire logic dominance,
  input wire logic setIn,
  input wire logic resetIn,
  // result
  output logic nextState
);
  wire logic bothOn = setIn & resetIn;
  wire logic bothWin = (dominance == NVL_DOM_SET);
  assign nextState = bothOn ? bothWin :
                     setIn ? 1'b1 :
                     resetIn ? 1'b0 :
                     current;
endmodule : nvl_latch_cell

/* rtl/nvl_latch_bank.sv */
// bank of sixteen persistent set/reset latches
// assumes an external non-volatile store restores a word at boot and takes
// every changed word; inputs are synchronous to clk
`timescale 1ns/1ps
// Summary of operation
// - sixteen independent latches, each own controls
// - state saved to and restored from store
// - dominance decides when set and reset together
// - set alone drives on high, off low
// - reset alone drives on low, off high
// - neither asserted keeps previous state
module nvl_latch_bank
  import nvl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // configuration and operands
  input wire logic [15:0] dominance,
  input wire logic [15:0] setIn,
  input wire logic [15:0] resetIn,
  // non-volatile store
  input wire nvl_word_type restore,
  output nvl_word_type save,
  // latch outputs
  output logic [15:0] latchOn,
  output logic [15:0] latchOff,
  output logic ready
);
  logic [1:0] syncRst_reg;
  wire logic rstLocal_b = syncRst_reg[1];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      syncRst_reg <= NVL_SYNC_RESET;
    end else begin
      syncRst_reg <= {syncRst_reg[0], 1'b1};
    end
  end

  nvl_state_type state_reg;
  nvl_state_type state_next;
  logic [15:0] store_reg;
  logic [15:0] store_next;
  logic [15:0] cellNext;

  // one cell per latch
  genvar gi;
  generate
    for (gi = 0; gi < NVL_COUNT; gi++) begin : g_cell
      nvl_latch_cell u_cell (
        .current(store_reg[gi]),
        .dominance(dominance[gi]),
        .setIn(setIn[gi]),
        .resetIn(resetIn[gi]),
        .nextState(cellNext[gi])
      );
    end
  endgenerate

  // wait for the store to hand back the saved word before running
  always_comb begin
    state_next = state_reg;
    store_next = store_reg;
    case (state_reg)
      NVL_ST_RESET: begin
        state_next = NVL_ST_RESTORE;
      end
      NVL_ST_RESTORE: begin
        if (restore.valid) begin
          store_next = restore.data;
          state_next = NVL_ST_RUN;
        end
      end
      NVL_ST_RUN: begin
        store_next = cellNext;
      end
      default: begin
        state_next = NVL_ST_RESET;
      end
    endcase
  end

  wire logic changed = (state_reg == NVL_ST_RUN) && (cellNext != store_reg);

  always_ff @(posedge clk or negedge rstLocal_b) begin
    if (!rstLocal_b) begin
      state_reg <= NVL_ST_RESET;
      store_reg <= NVL_CLEAR_ALL;
      latchOn <= NVL_CLEAR_ALL;
      // off reads all ones while waiting, so the pair stays complementary
      latchOff <= ~NVL_CLEAR_ALL;
      save <= '0;
      ready <= 1'b0;
    end else begin
      state_reg <= state_next;
      store_reg <= store_next;
      latchOn <= store_next;
      latchOff <= ~store_next;
      save.valid <= changed;
      save.data <= store_next;
      ready <= (state_next == NVL_ST_RUN);
    end
  end

  // checks
  sequence s_restored;
    (state_reg == NVL_ST_RESTORE) && restore.valid;
  endsequence

  // restore taken, then the bank runs from the next edge on
  sequence s_boot_done;
    s_restored ##1 ready;
  endsequence

  // one lane's operands, counted only while the bank runs
  sequence s_set_only(s, r);
    ready && s && !r;
  endsequence

  sequence s_reset_only(s, r);
    ready && r && !s;
  endsequence

  sequence s_both_on(s, r);
    ready && s && r;
  endsequence

  sequence s_idle_lane(s, r);
    ready && !s && !r;
  endsequence

  a_restore_loads: assert property (@(posedge clk) disable iff (!rstLocal_b)
    s_restored |=> (latchOn == $past(restore.data)) && ready)
    else $error("restored word not shown on outputs");
  a_save_change: assert property (@(posedge clk) disable iff (!rstLocal_b)
    ready && (latchOn != $past(latchOn)) && $past(ready) |-> save.valid
      && save.data == latchOn)
    else $error("latch change not saved");
  a_out_compl: assert property (@(posedge clk) disable iff (!rstLocal_b)
    (latchOn == ~latchOff))
    else $error("on and off not complementary");
  a_set_alone: assert property (@(posedge clk) disable iff (!rstLocal_b)
    ready && setIn[0] && !resetIn[0] |=> latchOn[0] && !latchOff[0])
    else $error("set alone did not set");
  a_reset_alone: assert property (@(posedge clk) disable iff (!rstLocal_b)
    ready && resetIn[0] && !setIn[0] |=> !latchOn[0] && latchOff[0])
    else $error("reset alone did not clear");
  a_hold_idle: assert property (@(posedge clk) disable iff (!rstLocal_b)
    ready && !setIn[0] && !resetIn[0] |=> $stable(latchOn[0]))
    else $error("idle latch changed");
  a_both_dom: assert property (@(posedge clk) disable iff (!rstLocal_b)
    ready && setIn[0] && resetIn[0] |=> latchOn[0] == $past(dominance[0]))
    else $error("dominance not honoured");
  a_high_lane: assert property (@(posedge clk) disable iff (!rstLocal_b)
    ready && setIn[15] && !resetIn[15] && !setIn[0] && !resetIn[0]
      |=> latchOn[15] && $stable(latchOn[0]))
    else $error("latches not independent");

  // start-up: nothing moves until the stored word is back
  a_boot_run: assert property (@(posedge clk) disable iff (!rstLocal_b)
    s_boot_done |-> (latchOff == ~latchOn) && !save.valid)
    else $error("bank did not start cleanly after restore");
  a_early_quiet: assert property (@(posedge clk) disable iff (!rstLocal_b)
    !ready |-> (latchOn == NVL_CLEAR_ALL) && !save.valid)
    else $error("outputs moved before restore");
  a_off_boot: assert property (@(posedge clk) disable iff (!rstLocal_b)
    !ready |-> (latchOff == ~NVL_CLEAR_ALL))
    else $error("off outputs not set while waiting");
  a_restore_off: assert property (@(posedge clk) disable iff (!rstLocal_b)
    s_restored |=> (latchOff == ~$past(restore.data)))
    else $error("restored word not inverted on off outputs");
  a_ready_start: assert property (@(posedge clk) disable iff (!rstLocal_b)
    $rose(ready) |-> $past(state_reg == NVL_ST_RESTORE) && $past(restore.valid))
    else $error("ready rose without a restored word");
  a_ready_stays: assert property (@(posedge clk) disable iff (!rstLocal_b)
    ready |=> ready)
    else $error("bank left run state");
  a_run_ignores: assert property (@(posedge clk) disable iff (!rstLocal_b)
    ready && restore.valid && !(|setIn) && !(|resetIn) |=> $stable(latchOn))
    else $error("restore applied while running");

  // the store sees every change and nothing else
  a_save_quiet: assert property (@(posedge clk) disable iff (!rstLocal_b)
    ready && $past(ready) && (latchOn == $past(latchOn)) |-> !save.valid)
    else $error("save without a change");
  a_save_whole: assert property (@(posedge clk) disable iff (!rstLocal_b)
    save.valid |-> (save.data == latchOn) && (save.data == ~latchOff))
    else $error("saved word differs from outputs");

  // every lane against its own truth table
  generate
    for (gi = 0; gi < NVL_COUNT; gi++) begin : g_check
      localparam int nbLane = (gi + 1) % NVL_COUNT;

      a_lane_set: assert property (@(posedge clk) disable iff (!rstLocal_b)
        s_set_only(setIn[gi], resetIn[gi]) |=> latchOn[gi] && !latchOff[gi])
        else $error("lane set alone did not set");
      a_lane_reset: assert property (@(posedge clk) disable iff (!rstLocal_b)
        s_reset_only(setIn[gi], resetIn[gi]) |=> !latchOn[gi] && latchOff[gi])
        else $error("lane reset alone did not clear");

      a_lane_hold: assert property (@(posedge clk) disable iff (!rstLocal_b)
        s_idle_lane(setIn[gi], resetIn[gi])
          |=> $stable(latchOn[gi]) && $stable(latchOff[gi]))
        else $error("idle lane changed");
      a_lane_both: assert property (@(posedge clk) disable iff (!rstLocal_b)
        s_both_on(setIn[gi], resetIn[gi]) |=> (latchOn[gi] == $past(dominance[gi]))
          && (latchOff[gi] != $past(dominance[gi])))
        else $error("lane dominance not honoured");

      a_lane_indep: assert property (@(posedge clk) disable iff (!rstLocal_b)
        ready && setIn[gi] && !resetIn[gi] && !setIn[nbLane] && !resetIn[nbLane]
          |=> $stable(latchOn[nbLane]))
        else $error("neighbour lane disturbed");

      a_lane_save: assert property (@(posedge clk) disable iff (!rstLocal_b)
        ready && $past(ready) && (latchOn[gi] != $past(latchOn[gi])) |-> save.valid)
        else $error("lane change not saved");
      a_lane_restore: assert property (@(posedge clk) disable iff (!rstLocal_b)
        s_restored |=> (latchOn[gi] == $past(restore.data[gi]))
          && (latchOff[gi] != $past(restore.data[gi])))
        else $error("lane not restored");
    end
  endgenerate
endmodule : nvl_latch_bank

/* verification/nvl_store_model.sv */
// behavioural non-volatile store: keeps each saved word, offers it at boot
// assumes save is synchronous to clk; bench presets the first word
`timescale 1ns/1ps
module nvl_store_model
  import nvl_pkg::*;
(
  // clock
  input wire logic clk,
  // preset
  input wire logic load,
  input wire logic [15:0] initWord,
  // bank side
  input wire nvl_word_type save,
  output nvl_word_type restore
);
  logic [15:0] wordReg;
  always @(posedge clk) begin
    if (load) wordReg <= initWord;
    else if (save.valid) wordReg <= save.data;
  end
  assign restore = '{valid: 1'h1, data: wordReg};
endmodule : nvl_store_model

/* verification/nvl_latch_bank_tb.sv */
// bench for the latch bank: power cycles through the store, truth table
// assumes the store model answers restore at once
`timescale 1ns/1ps
module nvl_latch_bank_tb;
  import nvl_pkg::*;
  logic clk, rst_b, load, ready;
  logic [15:0] dominance, setIn, resetIn, latchOn, latchOff, expWord;
  nvl_word_type restore, save;
  int error_cnt = 0;
  int n_compared = 0;
  logic [31:0] pat [8] = '{32'hF0F00000, 32'h0, 32'hFFFFFFFF, 32'h0F0F0000,
    32'h00003C3C, 32'hFFFFFFFF, 32'h0000FFFF, 32'h5AA50000};
  nvl_latch_bank nvl_latch_bank_inst (.clk(clk), .rst_b(rst_b), .dominance(dominance),
    .setIn(setIn), .resetIn(resetIn), .restore(restore), .save(save),
    .latchOn(latchOn), .latchOff(latchOff), .ready(ready));
  nvl_store_model nvl_store_model_inst (.clk(clk), .load(load), .initWord(16'hA5C3),
    .save(save), .restore(restore));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task report_and_stop;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  // power cycle, then the restored word must show on both outputs
  task boot_test;
    int i;
    // one edge first so a pending save reaches the store before power goes
    @(posedge clk) #1;
    rst_b = 0;
    // operands are refused until the stored word is back
    setIn = 16'hFFFF;
    resetIn = 16'h0000;
    repeat (16) @(posedge clk);
    #1 rst_b = 1;
    load = 0;
    for (i = 0; i < 20 && ready !== 1'h1; i++) @(posedge clk) #1;
    if (ready !== 1'h1) begin
      error_cnt++;
      report_and_stop();
    end
    check({15'h0, ready}, 16'h0001);
    check(latchOn, expWord);
    check(latchOff, ~expWord);
    $display("boot test done");
  endtask : boot_test
  task step(input logic [15:0] s, input logic [15:0] r);
    logic [15:0] nxt;
    nxt = (s & ~r) | (s & r & dominance) | (~s & ~r & expWord);
    setIn = s;
    resetIn = r;
    @(posedge clk) #1;
    check(latchOn, nxt);
    check(latchOff, ~nxt);
    check({15'h0, save.valid}, {15'h0, nxt != expWord});
    if (nxt != expWord) check(save.data, nxt);
    expWord = nxt;
  endtask : step
  // every set/reset pairing, with both-on under both dominance settings, back to back
  task table_test;
    foreach (pat[i]) begin
      if (i == 3) dominance = 16'hFF00;
      step(pat[i][31:16], pat[i][15:0]);
    end
    $display("table test done");
  endtask : table_test
  initial begin
    {rst_b, setIn, resetIn} = '0;
    dominance = 16'h00FF;
    load = 1;
    expWord = 16'hA5C3;
    boot_test();
    table_test();
    boot_test();
    report_and_stop();
  end
endmodule : nvl_latch_bank_tb
